// ==== design/hdc_config_bank.sv ====
`timescale 1ns/1ns
`include "hdc_params.svh"

module hdc_config_bank
    import hdc_pkg::*;
#(
    parameter int unsigned SETTLE_TICKS = `HDC_SETTLE_UNIT_NS / `HDC_CLK_PERIOD_NS
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire hdc_cfg_req_t cfg_req,
    output logic [7:0]        cfg_rdata,
    output logic              cfg_rvalid,
    input  wire logic         port_power_start,
    output logic              port_power_ready,
    input  wire logic         text_req,
    output logic              text_busy,
    output hdc_char_t         text_char,
    output hdc_desc_t         desc
);

    localparam logic [23:0] TICK_LAST = 24'(SETTLE_TICKS - 1);

    hdc_regs_t s_q;
    hdc_regs_t s_d;

    // ****************************************
    // Address decode
    // ****************************************

    // Shared by the read and write paths
    function automatic logic is_text(input logic [7:0] a);
        is_text = (a >= `HDC_OFF_TEXT_FIRST) && (a <= `HDC_OFF_TEXT_LAST);
    endfunction

    function automatic logic [7:0] clamp_cnt(input logic [7:0] v);
        clamp_cnt = (v > `HDC_MAX_CHARS) ? `HDC_MAX_CHARS : v;
    endfunction

    logic [5:0] text_off;
    assign text_off = 6'(cfg_req.addr - `HDC_OFF_TEXT_FIRST);

    // ****************************************
    // Next state
    // ****************************************

    // Register writes, registered reads, settle timer, string readout
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.chr.valid = 1'b0;
        s_d.chr.last = 1'b0;
        if (cfg_req.wr) begin
            unique case (cfg_req.addr)
                `HDC_OFF_CUR_SP:    s_d.desc.cur_sp = cfg_req.wdata;
                `HDC_OFF_CUR_BP:    s_d.desc.cur_bp = cfg_req.wdata;
                `HDC_OFF_SETTLE:    s_d.desc.settle = cfg_req.wdata;
                `HDC_OFF_LANG_HI:   s_d.desc.lang[15:8] = cfg_req.wdata;
                `HDC_OFF_LANG_LO:   s_d.desc.lang[7:0] = cfg_req.wdata;
                // Oversized counts saturate so readout never leaves storage
                `HDC_OFF_MAKER_CNT: s_d.desc.maker_cnt = clamp_cnt(cfg_req.wdata);
                `HDC_OFF_ITEM_CNT:  s_d.desc.item_cnt = clamp_cnt(cfg_req.wdata);
                `HDC_OFF_UNIT_CNT:  s_d.desc.unit_cnt = clamp_cnt(cfg_req.wdata);
                default: begin
                    if (is_text(cfg_req.addr)) begin
                        s_d.text[text_off] = cfg_req.wdata;
                    end
                end
            endcase
        end
        if (cfg_req.rd) begin
            s_d.rvalid = 1'b1;
            unique case (cfg_req.addr)
                `HDC_OFF_CUR_SP:    s_d.rdata = s_q.desc.cur_sp;
                `HDC_OFF_CUR_BP:    s_d.rdata = s_q.desc.cur_bp;
                `HDC_OFF_SETTLE:    s_d.rdata = s_q.desc.settle;
                `HDC_OFF_LANG_HI:   s_d.rdata = s_q.desc.lang[15:8];
                `HDC_OFF_LANG_LO:   s_d.rdata = s_q.desc.lang[7:0];
                `HDC_OFF_MAKER_CNT: s_d.rdata = s_q.desc.maker_cnt;
                `HDC_OFF_ITEM_CNT:  s_d.rdata = s_q.desc.item_cnt;
                `HDC_OFF_UNIT_CNT:  s_d.rdata = s_q.desc.unit_cnt;
                default: begin
                    s_d.rdata = is_text(cfg_req.addr) ? s_q.text[text_off] : `HDC_UNMAPPED_DATA;
                end
            endcase
        end

        // Settle timer: one unit is SETTLE_TICKS cycles
        if (port_power_start) begin
            s_d.settling = 1'b1;
            s_d.ready = 1'b0;
            s_d.units = s_q.desc.settle;
            s_d.tick = '0;
        end else if (s_q.settling) begin
            if (s_q.units == 8'h00) begin
                s_d.settling = 1'b0;
                s_d.ready = 1'b1;
            end else if (s_q.tick == TICK_LAST) begin
                s_d.tick = '0;
                s_d.units = s_q.units - 8'h01;
            end else begin
                s_d.tick = s_q.tick + 24'h000001;
            end
        end

        // Maker string readout, one character per cycle
        unique case (s_q.st)
            HDC_IDLE: begin
                if (text_req && (s_q.desc.maker_cnt != 8'h00)) begin
                    s_d.st = HDC_SEND;
                    s_d.idx = '0;
                    s_d.sent = '0;
                end
            end
            HDC_SEND: begin
                // Low byte from the even address, high byte from the next
                s_d.chr.valid = 1'b1;
                s_d.chr.code = {s_q.text[{s_q.idx, 1'b1}], s_q.text[{s_q.idx, 1'b0}]};
                s_d.sent = s_q.sent + 6'h01;
                s_d.idx = s_q.idx + 5'h01;
                if (6'(s_q.idx) + 6'h01 == s_q.desc.maker_cnt[5:0]) begin
                    s_d.chr.last = 1'b1;
                    s_d.st = HDC_IDLE;
                end
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************

    // Counts reset to zero; only the two current registers have a set default
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.desc.cur_sp <= `HDC_CUR_RESET;
            s_q.desc.cur_bp <= `HDC_CUR_RESET;
            s_q.desc.settle <= `HDC_CFG_RESET;
            s_q.st <= HDC_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign cfg_rdata = s_q.rdata;
    assign cfg_rvalid = s_q.rvalid;
    assign port_power_ready = s_q.ready;
    // One-hot state, so the send bit itself is the busy flag
    assign text_busy = s_q.st[1];
    assign text_char = s_q.chr;
    assign desc = s_q.desc;

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_self_cur_default: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (desc.cur_sp == `HDC_CUR_RESET)) else $error("self-powered current default wrong");
    a_bus_cur_default: assert property (@(posedge clk) disable iff (1'b0)
        reset |=> (desc.cur_bp == `HDC_CUR_RESET)) else $error("bus-powered current default wrong");
    a_self_cur_read: assert property (
        (cfg_req.rd && cfg_req.addr == `HDC_OFF_CUR_SP) |=> (cfg_rvalid && cfg_rdata == $past(desc.cur_sp)))
        else $error("self-powered current readback wrong");
    a_bus_cur_write: assert property (
        (cfg_req.wr && cfg_req.addr == `HDC_OFF_CUR_BP) |=> (desc.cur_bp == $past(cfg_req.wdata)))
        else $error("bus-powered current write lost");
    a_lang_upper: assert property (
        (cfg_req.wr && cfg_req.addr == `HDC_OFF_LANG_HI) |=> (desc.lang[15:8] == $past(cfg_req.wdata)))
        else $error("language upper byte wrong");
    a_lang_lower: assert property (
        (cfg_req.wr && cfg_req.addr == `HDC_OFF_LANG_LO) |=> (desc.lang[7:0] == $past(cfg_req.wdata)))
        else $error("language lower byte wrong");
    a_count_clamp: assert property (
        (cfg_req.wr && cfg_req.addr == `HDC_OFF_MAKER_CNT && cfg_req.wdata > `HDC_MAX_CHARS)
        |=> (desc.maker_cnt == `HDC_MAX_CHARS)) else $error("string count not limited");
    a_text_top_byte: assert property (
        (cfg_req.wr && cfg_req.addr == `HDC_OFF_TEXT_LAST) |=> (s_q.text[61] == $past(cfg_req.wdata)))
        else $error("last string byte not stored");
    a_first_char_order: assert property (
        (text_req && !text_busy && desc.maker_cnt != 8'h00)
        |=> ##1 (text_char.valid && text_char.code == {$past(s_q.text[1]), $past(s_q.text[0])}))
        else $error("first character byte order wrong");
    a_char_count: assert property (
        text_char.last |-> (text_char.valid && 8'(s_q.sent) == desc.maker_cnt))
        else $error("character count mismatch");
    a_settle_zero: assert property (
        (port_power_start && desc.settle == 8'h00) |=> !port_power_ready ##1 port_power_ready)
        else $error("zero settle delay not immediate");

    // Readback, restart, unmapped space, end of stream and item count limit
    a_bus_cur_read: assert property (
        (cfg_req.rd && cfg_req.addr == `HDC_OFF_CUR_BP) |=> (cfg_rvalid && cfg_rdata == $past(desc.cur_bp)))
        else $error("bus-powered current readback wrong");
    a_settle_restart: assert property (
        port_power_start |=> !port_power_ready)
        else $error("ready not dropped on power start");
    a_unmapped_read: assert property (
        (cfg_req.rd && cfg_req.addr > `HDC_OFF_TEXT_LAST) |=> (cfg_rdata == `HDC_UNMAPPED_DATA))
        else $error("read beyond string region not empty");
    a_last_idle: assert property (
        text_char.last |-> !text_busy)
        else $error("readout still busy on last character");
    a_item_clamp: assert property (
        (cfg_req.wr && cfg_req.addr == `HDC_OFF_ITEM_CNT && cfg_req.wdata > `HDC_MAX_CHARS)
        |=> (desc.item_cnt == `HDC_MAX_CHARS)) else $error("item string count not limited");

endmodule

// ==== design/hdc_params.svh ====
`ifndef HDC_PARAMS_SVH
`define HDC_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define HDC_OFF_CUR_SP      8'h0e
`define HDC_OFF_CUR_BP      8'h0f
`define HDC_OFF_SETTLE      8'h10
`define HDC_OFF_LANG_HI     8'h11
`define HDC_OFF_LANG_LO     8'h12
`define HDC_OFF_MAKER_CNT   8'h13
`define HDC_OFF_ITEM_CNT    8'h14
`define HDC_OFF_UNIT_CNT    8'h15
`define HDC_OFF_TEXT_FIRST  8'h16
`define HDC_OFF_TEXT_LAST   8'h53

// ****************************************
// Reset values and limits
// ****************************************
`define HDC_CUR_RESET       8'h32
`define HDC_CFG_RESET       8'h00
`define HDC_MAX_CHARS       8'h1f
`define HDC_TEXT_BYTES      62
`define HDC_UNMAPPED_DATA   8'h00

// ****************************************
// Timing
// ****************************************
`define HDC_CLK_PERIOD_NS   100
`define HDC_SETTLE_UNIT_NS  2000000

`endif

// ==== design/hdc_pkg.sv ====
package hdc_pkg;

    // Byte-wide configuration access from the loader
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hdc_cfg_req_t;

    // Values reported upstream in descriptors
    typedef struct packed {
        logic [7:0]  cur_sp;
        logic [7:0]  cur_bp;
        logic [7:0]  settle;
        logic [15:0] lang;
        logic [7:0]  maker_cnt;
        logic [7:0]  item_cnt;
        logic [7:0]  unit_cnt;
    } hdc_desc_t;

    // One UTF-16LE character of the maker string
    typedef struct packed {
        logic        valid;
        logic        last;
        logic [15:0] code;
    } hdc_char_t;

    typedef enum logic [1:0] {
        HDC_IDLE = 2'b01,
        HDC_SEND = 2'b10
    } hdc_state_t;

    typedef struct packed {
        hdc_desc_t        desc;
        logic [61:0][7:0] text;
        logic [7:0]       rdata;
        logic             rvalid;
        hdc_state_t       st;
        logic [4:0]       idx;
        logic [5:0]       sent;
        hdc_char_t        chr;
        logic [23:0]      tick;
        logic [7:0]       units;
        logic             settling;
        logic             ready;
    } hdc_regs_t;

endpackage

// ==== tb/hdc_loader.sv ====
`timescale 1ns/1ns
`include "hdc_params.svh"

// ****************************************
// Loader model: serial EEPROM or SMBus host
// ****************************************
module hdc_loader
    import hdc_pkg::*;
(
    input  wire logic         clk,
    output hdc_cfg_req_t      cfg_req,
    input  wire logic [7:0]   cfg_rdata,
    input  wire logic         cfg_rvalid
);
    initial cfg_req = '0;

    // Byte write; address and data inverted after release so stale values never look valid
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Byte read; data taken in the one cycle that it is flagged valid
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
        @(posedge clk);
        cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
        #1;
        d = (cfg_rvalid === 1'b1) ? cfg_rdata : 8'hxx;
    endtask

    // Character k stored low byte first, high byte at the next address
    task automatic wr_char(input int k, input logic [15:0] c);
        wr_byte(`HDC_OFF_TEXT_FIRST + 8'(2 * k), c[7:0]);
        wr_byte(`HDC_OFF_TEXT_FIRST + 8'(2 * k + 1), c[15:8]);
    endtask
endmodule

// ==== tb/hdc_config_bank_test.sv ====
`timescale 1ns/1ns
`include "hdc_params.svh"

// ****************************************
// Testbench
// ****************************************
module hdc_config_bank_test import hdc_pkg::*;;
    localparam int TICKS = 4;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic         port_power_start = 1'b0;
    logic         text_req = 1'b0;
    hdc_cfg_req_t cfg_req;
    logic [7:0]   cfg_rdata;
    logic         cfg_rvalid;
    logic         port_power_ready;
    logic         text_busy;
    hdc_char_t    text_char;
    hdc_desc_t    desc;
    int           error_cnt = 0;
    int           n_tests = 0;
    int           n;
    logic [7:0]   rd;
    logic [15:0]  chars [3] = '{16'h0041, 16'h0062, 16'h20e9};

    always #50 clk = ~clk;

    hdc_config_bank #(.SETTLE_TICKS(TICKS)) hdc_config_bank_i (.clk(clk), .reset(reset), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .port_power_start(port_power_start),
        .port_power_ready(port_power_ready), .text_req(text_req), .text_busy(text_busy),
        .text_char(text_char), .desc(desc));
    hdc_loader hdc_loader_i (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard, well beyond the hundred or so cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // Reset values: currents at 100 mA, the rest cleared
        for (int a = 8'h0e; a <= 8'h15; a++) begin
            hdc_loader_i.rd_byte(8'(a), rd);
            check(rd, (a < 8'h10) ? 8'h32 : 8'h00);
        end
        check(desc.cur_sp, 8'h32);
        check(desc.cur_bp, 8'h32);
        check(port_power_ready, 1'b0);
        check(text_busy, 1'b0);
        $display("reset values done");
        // Currents, settle delay and language ID written and reported
        hdc_loader_i.wr_byte(`HDC_OFF_CUR_SP, 8'h31);
        hdc_loader_i.wr_byte(`HDC_OFF_CUR_BP, 8'hfa);
        hdc_loader_i.wr_byte(`HDC_OFF_LANG_HI, 8'h04);
        hdc_loader_i.wr_byte(`HDC_OFF_LANG_LO, 8'h09);
        hdc_loader_i.wr_byte(`HDC_OFF_SETTLE, 8'h02);
        hdc_loader_i.rd_byte(`HDC_OFF_CUR_BP, rd);
        check(rd, 8'hfa);
        check(desc.cur_sp, 8'h31);
        check(desc.cur_bp, 8'hfa);
        check(desc.lang, 16'h0409);
        check(desc.settle, 8'h02);
        $display("descriptor fields done");
        // Count limit at 31, unmapped places outside the string region
        hdc_loader_i.wr_byte(`HDC_OFF_ITEM_CNT, 8'h40);
        hdc_loader_i.wr_byte(`HDC_OFF_UNIT_CNT, 8'h1f);
        hdc_loader_i.rd_byte(`HDC_OFF_ITEM_CNT, rd);
        check(rd, 8'h1f);
        hdc_loader_i.rd_byte(`HDC_OFF_UNIT_CNT, rd);
        check(rd, 8'h1f);
        hdc_loader_i.wr_byte(`HDC_OFF_MAKER_CNT, 8'hff);
        hdc_loader_i.rd_byte(`HDC_OFF_MAKER_CNT, rd);
        check(rd, 8'h1f);
        hdc_loader_i.wr_byte(`HDC_OFF_TEXT_LAST, 8'h77);
        hdc_loader_i.wr_byte(8'h54, 8'ha5);
        hdc_loader_i.rd_byte(`HDC_OFF_TEXT_LAST, rd);
        check(rd, 8'h77);
        hdc_loader_i.rd_byte(8'h54, rd);
        check(rd, 8'h00);
        $display("limits done");
        // String readout: three characters, only as many as the count says
        for (int k = 0; k < 4; k++) hdc_loader_i.wr_char(k, (k < 3) ? chars[k] : 16'hbeef);
        hdc_loader_i.wr_byte(`HDC_OFF_MAKER_CNT, 8'h03);
        @(posedge clk);
        text_req <= 1'b1;
        @(posedge clk);
        text_req <= 1'b0;
        n = 0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (text_char.valid === 1'b1) begin
                check(text_char.code, (n < 3) ? chars[n] : 16'hxxxx);
                check(text_char.last, n == 2);
                check(text_busy, 1'(n != 2));
                n++;
            end
        end
        check(16'(n), 16'h0003);
        $display("string readout done");
        // Settle timer: ready sampled at edge settle * ticks + 2, seen here 1 ns after edge settle * ticks + 1
        for (int s = 2; s >= 0; s -= 2) begin
            hdc_loader_i.wr_byte(`HDC_OFF_SETTLE, 8'(s));
            @(posedge clk);
            port_power_start <= 1'b1;
            @(posedge clk);
            port_power_start <= 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (port_power_ready !== 1'b1 && n < 100);
            check(16'(n), 16'(s * TICKS + 1));
        end
        $display("settle timer done");
        end_sim();
    end
endmodule
